// File: logic/uart_modem_status_tracker.sv
// Modem status tracker: line levels, change bits, interrupts, auto flow gate, scratch byte.
//
// Overview of operation
// (RQ1) Auto flow: stop new characters while line deasserted
// (RQ2) Status bit 4: inverted line, or RTS in loopback
// (RQ3) Bit 3 set on carrier-detect change since read
// (RQ4) Bit 2 set only on ring pin rising
// (RQ5) Bit 1 set on data-set-ready change since read
// (RQ6) Bit 0 set on clear-to-send change since read
// (RQ7) Any change bit set raises modem interrupt request
// (RQ8) Eight-bit scratch byte, write and read back
// (RQ9) Reading status clears all four change bits
// (RQ10) Bit 7: inverted carrier line, or output two
// (RQ11) Bit 6: inverted ring line, or output one
// (RQ12) Bit 5: inverted data-set-ready, or DTR in loopback
// (RQ13) Synchronise inputs; change on read is kept
`timescale 1ns/1ps
module uart_modem_status_tracker
    import modem_status_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // Modem input pins, active low
    input  wire logic              cts_n,
    input  wire logic              dsr_n,
    input  wire logic              ri_n,
    input  wire logic              dcd_n,
    // Modem output pins, active low
    output logic                   dtr_n,
    output logic                   rts_n,
    output logic                   user_output_one_n,
    output logic                   user_output_two_n,
    // Transmitter handshake
    input  wire logic              tx_busy,
    output logic                   tx_enable,
    // Interrupts
    output logic                   msi_req,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [CTL_W-1:0]  ctrl_reg;
    logic [CTL_W-1:0]  ctrl_next;
    logic [DATA_W-1:0] feat_reg;
    logic [DATA_W-1:0] feat_next;
    logic [DATA_W-1:0] scratch_reg;
    logic [DATA_W-1:0] scratch_next;
    logic [LINE_N-1:0] mask_reg;
    logic [LINE_N-1:0] mask_next;
    logic [LINE_N-1:0] status_reg;
    logic [LINE_N-1:0] status_next;
    logic [LINE_N-1:0] delta_reg;
    logic [LINE_N-1:0] delta_next;
    logic [LINE_N-1:0] irq_stat_reg;
    logic [LINE_N-1:0] irq_stat_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              tx_enable_reg;
    logic              tx_enable_next;
    logic              msi_req_reg;
    logic              msi_req_next;
    logic              irq_reg;
    logic              irq_next;
    logic              dtr_n_reg;
    logic              dtr_n_next;
    logic              rts_n_reg;
    logic              rts_n_next;
    logic              user_output_one_n_reg;
    logic              user_output_one_n_next;
    logic              user_output_two_n_reg;
    logic              user_output_two_n_next;
    logic [LINE_N-1:0] loop_src;
    logic [LINE_N-1:0] event_hit;
    logic              status_read;
    logic              loop_on;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchroniser
    modem_sync_if #(.LINES(LINE_N)) sync_bus ();

    // Pin order follows the line index used by the status register
    always_comb begin
        sync_bus.raw_n           = PIN_IDLE;
        sync_bus.raw_n[LINE_CTS] = cts_n;
        sync_bus.raw_n[LINE_DSR] = dsr_n;
        sync_bus.raw_n[LINE_RI]  = ri_n;
        sync_bus.raw_n[LINE_DCD] = dcd_n;
    end

    modem_line_sync #(
        .LINES (LINE_N)
    ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .lines (sync_bus.sync_side)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Level source selection
    assign loop_on = ctrl_reg[CTL_LOOP];

    // Loopback feeds the status bits from our own output controls
    always_comb begin
        loop_src           = LINE_ZERO;
        loop_src[LINE_CTS] = ctrl_reg[CTL_RTS];   // [RQ2]
        loop_src[LINE_DSR] = ctrl_reg[CTL_DTR];   // [RQ12]
        loop_src[LINE_RI]  = ctrl_reg[CTL_USER_OUTPUT_ONE];  // [RQ11]
        loop_src[LINE_DCD] = ctrl_reg[CTL_USER_OUTPUT_TWO];  // [RQ10]
    end

    // Status levels are the complement of the synchronised pins outside loopback
    always_comb begin
        if (loop_on) begin
            status_next = loop_src;               // [RQ2] [RQ10] [RQ11] [RQ12]
        end else begin
            status_next = ~sync_bus.synced_n;     // [RQ2] [RQ10] [RQ11] [RQ12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change detection, one lane per line
    genvar i;
    generate
        for (i = 0; i < LINE_N; i++) begin : g_event
            if (i == LINE_RI) begin : g_ring
                // Pin rising is the status bit falling; the other edge is ignored
                assign event_hit[i] = status_reg[i] & ~status_next[i];   // [RQ4]
            end else begin : g_toggle
                // Either direction counts as a change
                assign event_hit[i] = status_reg[i] ^ status_next[i];    // [RQ3] [RQ5] [RQ6]
            end
        end
    endgenerate

    assign status_read = rd && (addr == ADDR_LINE_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // Change bits: read clears, a change in the same cycle still wins
    always_comb begin
        delta_next = delta_reg;
        if (status_read) begin
            delta_next = LINE_ZERO;               // [RQ9]
        end
        delta_next = delta_next | event_hit;      // [RQ13] [RQ3] [RQ4] [RQ5] [RQ6]
    end

    // Modem interrupt request follows the change bits, not the mask
    always_comb begin
        msi_req_next = |delta_next;               // [RQ7]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers
    always_comb begin
        ctrl_next    = ctrl_reg;
        feat_next    = feat_reg;
        scratch_next = scratch_reg;
        mask_next    = mask_reg;
        if (wr) begin
            case (addr)
                ADDR_LINE_CONTROL: begin
                    ctrl_next = wdata[CTL_W-1:0];
                end
                ADDR_FEATURE: begin
                    feat_next = wdata;
                end
                ADDR_SCRATCH: begin
                    scratch_next = wdata;         // [RQ8]
                end
                ADDR_IRQ_MASK: begin
                    mask_next = wdata[LINE_N-1:0];
                end
                default: begin
                    // Line status and unmapped offsets ignore writes; interrupt status writes are handled below
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status: write one to clear, new event beats the clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr && (addr == ADDR_IRQ_STATUS)) begin
            irq_stat_next = irq_stat_reg & ~wdata[LINE_N-1:0];
        end
        irq_stat_next = irq_stat_next | event_hit;
        irq_next      = |(irq_stat_next & mask_next);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto flow gate
    // Decision is only taken between characters, so a character already on
    // the wire always completes; the cost is up to one extra character latency
    always_comb begin
        tx_enable_next = tx_enable_reg;
        if (!tx_busy) begin
            tx_enable_next = !(feat_reg[FEAT_AUTO_CTS] && !status_reg[LINE_CTS]);   // [RQ1]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins; held inactive in loopback so the far end sees nothing
    always_comb begin
        dtr_n_next  = ~ctrl_next[CTL_DTR];
        rts_n_next  = ~ctrl_next[CTL_RTS];
        user_output_one_n_next = ~ctrl_next[CTL_USER_OUTPUT_ONE];
        user_output_two_n_next = ~ctrl_next[CTL_USER_OUTPUT_TWO];
        if (ctrl_next[CTL_LOOP]) begin
            dtr_n_next  = 1'b1;
            rts_n_next  = 1'b1;
            user_output_one_n_next = 1'b1;
            user_output_two_n_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; data valid only in the cycle after the strobe
    always_comb begin
        rdata_next = DATA_ZERO;
        if (rd) begin
            case (addr)
                ADDR_LINE_CONTROL: begin
                    rdata_next[CTL_W-1:0] = ctrl_reg;
                end
                ADDR_FEATURE: begin
                    rdata_next = feat_reg;
                end
                ADDR_LINE_STATUS: begin
                    // Value before the clear is returned
                    rdata_next = {status_reg, delta_reg};   // [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
                end
                ADDR_SCRATCH: begin
                    rdata_next = scratch_reg;               // [RQ8]
                end
                ADDR_IRQ_STATUS: begin
                    rdata_next[LINE_N-1:0] = irq_stat_reg;
                end
                ADDR_IRQ_MASK: begin
                    rdata_next[LINE_N-1:0] = mask_reg;
                end
                default: begin
                    rdata_next = DATA_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg      <= CTL_RESET;
            feat_reg      <= FEAT_RESET;
            scratch_reg   <= SCRATCH_RESET;
            mask_reg      <= LINE_ZERO;
            status_reg    <= LINE_ZERO;
            delta_reg     <= LINE_ZERO;
            irq_stat_reg  <= LINE_ZERO;
            rdata_reg     <= DATA_ZERO;
            tx_enable_reg <= 1'b1;
            msi_req_reg   <= 1'b0;
            irq_reg       <= 1'b0;
            dtr_n_reg     <= 1'b1;
            rts_n_reg     <= 1'b1;
            user_output_one_n_reg    <= 1'b1;
            user_output_two_n_reg    <= 1'b1;
        end else begin
            ctrl_reg      <= ctrl_next;
            feat_reg      <= feat_next;
            scratch_reg   <= scratch_next;
            mask_reg      <= mask_next;
            status_reg    <= status_next;
            delta_reg     <= delta_next;
            irq_stat_reg  <= irq_stat_next;
            rdata_reg     <= rdata_next;
            tx_enable_reg <= tx_enable_next;
            msi_req_reg   <= msi_req_next;
            irq_reg       <= irq_next;
            dtr_n_reg     <= dtr_n_next;
            rts_n_reg     <= rts_n_next;
            user_output_one_n_reg    <= user_output_one_n_next;
            user_output_two_n_reg    <= user_output_two_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign rdata     = rdata_reg;
    assign tx_enable = tx_enable_reg;
    assign msi_req   = msi_req_reg;
    assign irq       = irq_reg;
    assign dtr_n     = dtr_n_reg;
    assign rts_n     = rts_n_reg;
    assign user_output_one_n    = user_output_one_n_reg;
    assign user_output_two_n    = user_output_two_n_reg;

endmodule : uart_modem_status_tracker

// File: logic/modem_status_pkg.sv
// Shared constants for the modem status tracker: register map, field layout, reset values.
package modem_status_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int LINE_N = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_LINE_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_FEATURE      = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_SCRATCH      = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK     = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // Modem line index: same order as the change bits 0..3 and level bits 4..7
    localparam int LINE_CTS = 0;
    localparam int LINE_DSR = 1;
    localparam int LINE_RI  = 2;
    localparam int LINE_DCD = 3;

    ////////////////////////////////////////////////////////////////////////////
    // modem_line_control fields
    localparam int CTL_DTR  = 0;
    localparam int CTL_RTS  = 1;
    localparam int CTL_USER_OUTPUT_ONE = 2;
    localparam int CTL_USER_OUTPUT_TWO = 3;
    localparam int CTL_LOOP = 4;
    localparam int CTL_W    = 5;

    // enhanced_feature_control field
    localparam int FEAT_AUTO_CTS = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [CTL_W-1:0]  CTL_RESET     = 5'h00;
    localparam logic [DATA_W-1:0] FEAT_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] SCRATCH_RESET = 8'h00;
    localparam logic [LINE_N-1:0] LINE_ZERO     = 4'h0;
    localparam logic [LINE_N-1:0] PIN_IDLE      = 4'hF;
    localparam logic [DATA_W-1:0] DATA_ZERO     = 8'h00;

endpackage : modem_status_pkg

// File: logic/modem_sync_if.sv
// Carrier between the top and the modem input synchroniser.
`timescale 1ns/1ps
interface modem_sync_if #(
    parameter int LINES = 4
);
    logic [LINES-1:0] raw_n;
    logic [LINES-1:0] synced_n;

    modport sync_side (input raw_n, output synced_n);
    modport user_side (output raw_n, input synced_n);
endinterface : modem_sync_if

// File: logic/modem_line_sync.sv
// Two-stage synchroniser for the active-low modem input lines.
`timescale 1ns/1ps
module modem_line_sync
    import modem_status_pkg::*;
#(
    parameter int LINES = LINE_N
) (
    input wire logic      clk,
    input wire logic      rst,
    modem_sync_if.sync_side lines
);

    logic [LINES-1:0] meta_reg;
    logic [LINES-1:0] meta_next;
    logic [LINES-1:0] sync_reg;
    logic [LINES-1:0] sync_next;

    ////////////////////////////////////////////////////////////////////////////
    // Per-line stages; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < LINES; i++) begin : g_line
            always_comb begin
                meta_next[i] = lines.raw_n[i];   // [RQ13]
                sync_next[i] = meta_reg[i];      // [RQ13]
            end
        end
    endgenerate

    // Idle level is high so a quiet line shows no change after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= PIN_IDLE[LINES-1:0];
            sync_reg <= PIN_IDLE[LINES-1:0];
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign lines.synced_n = sync_reg;

endmodule : modem_line_sync

// File: test/modem_status_checker.sv
// Checker for the tracker ports.
`timescale 1ns/1ps
module modem_status_checker
    import modem_status_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              cts_n,
    input wire logic              dsr_n,
    input wire logic              ri_n,
    input wire logic              dcd_n,
    input wire logic              dtr_n,
    input wire logic              rts_n,
    input wire logic              user_output_one_n,
    input wire logic              user_output_two_n,
    input wire logic              tx_busy,
    input wire logic              tx_enable,
    input wire logic              msi_req,
    input wire logic              irq
);
    logic [3:0]        pins_reg;
    logic [2:0]        quiet_reg, quiet_next;
    logic [DATA_W-1:0] wd_reg, scr_reg, scr_next;
    logic              auto_reg, auto_next;
    logic              wctl, wscr, wfeat;

    ////////////////////////////////////////
    // Host write shadows; quiet counts edges without pin moves or writes, as those start events
    assign wctl = wr && addr == ADDR_LINE_CONTROL;
    assign wscr = wr && addr == ADDR_SCRATCH;
    assign wfeat = wr && addr == ADDR_FEATURE;
    always_comb begin
        quiet_next = (wr || pins_reg != {dcd_n, ri_n, dsr_n, cts_n}) ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
        scr_next = wscr ? wdata : scr_reg;
        auto_next = wfeat ? wdata[FEAT_AUTO_CTS] : auto_reg;
    end
    always_ff @(posedge clk) begin
        pins_reg <= {dcd_n, ri_n, dsr_n, cts_n};
        wd_reg <= wdata;
        quiet_reg <= rst ? 3'h0 : quiet_next;
        scr_reg <= rst ? SCRATCH_RESET : scr_next;
        auto_reg <= rst ? 1'b0 : auto_next;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    // Port relations
    a_rdata_idle: assert property (!$past(rd) |-> rdata == DATA_ZERO)
        else $error("read data not zero outside answer cycle");
    a_read_clears: assert property (rd && addr == ADDR_LINE_STATUS && quiet_reg >= 3'h5 |=> ##1 !msi_req)
        else $error("status read did not clear request");
    a_msi_quiet: assert property (quiet_reg == 3'h7 && !msi_req |=> !msi_req)
        else $error("request rose without cause");
    a_loop_pins: assert property (wctl && wdata[CTL_LOOP] |=> {dtr_n, rts_n, user_output_one_n, user_output_two_n} == 4'hF)
        else $error("outputs not idle in loopback");
    a_ctl_pins: assert property (wctl && !wdata[CTL_LOOP] |=> {user_output_two_n, user_output_one_n, rts_n, dtr_n} == ~wd_reg[3:0])
        else $error("outputs differ from control");
    a_scratch_read: assert property (rd && addr == ADDR_SCRATCH |=> rdata == scr_reg)
        else $error("scratch read mismatch");
    a_flow_hold: assert property (tx_busy |=> tx_enable == $past(tx_enable))
        else $error("gate moved during character");
    a_flow_free: assert property (!auto_reg && !tx_busy |=> tx_enable)
        else $error("gate closed with auto flow off");
    a_irq_masked: assert property (wr && addr == ADDR_IRQ_MASK && wdata[3:0] == 4'h0 |=> ##1 !irq)
        else $error("irq high with all masked");
    c_flow_stop: cover property (auto_reg && $fell(tx_enable));
    c_msi_seen: cover property ($rose(msi_req));
    c_irq_seen: cover property ($rose(irq));
endmodule : modem_status_checker

// File: test/modem_peer.sv
// Behavioural modem driving the active-low handshake lines.
`timescale 1ns/1ps
module modem_peer (
    input  wire logic       clk,
    input  wire logic [3:0] want_n,
    input  wire logic       slow,
    output logic      [3:0] line_n
);
    logic [3:0] stage_reg;

    ////////////////////////////////////////
    // Slow mode answers one edge later, like a sluggish modem
    always_ff @(posedge clk) begin
        stage_reg <= want_n;
        line_n <= slow ? stage_reg : want_n;
    end
endmodule : modem_peer

// File: test/tb_uart_modem_status_tracker.sv
// Self-checking bench for the modem status tracker.
`timescale 1ns/1ps
module tb_uart_modem_status_tracker
    import modem_status_pkg::*;
();
    logic              clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tx_busy = 1'b0, slow = 1'b0;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wdata = 8'h00, rdata, q;
    logic [3:0]        want_n = 4'hF, line_n, ctl_n;
    logic              tx_enable, msi_req, irq;
    int                errors = 0, comparisons = 0;
    int                lb[4] = '{5, 4, 6, 7};

    always #10 clk = ~clk;
    modem_peer peer (.clk(clk), .want_n(want_n), .slow(slow), .line_n(line_n));
    uart_modem_status_tracker DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cts_n(line_n[LINE_CTS]), .dsr_n(line_n[LINE_DSR]), .ri_n(line_n[LINE_RI]),
        .dcd_n(line_n[LINE_DCD]), .dtr_n(ctl_n[0]), .rts_n(ctl_n[1]), .user_output_one_n(ctl_n[2]), .user_output_two_n(ctl_n[3]),
        .tx_busy(tx_busy), .tx_enable(tx_enable), .msi_req(msi_req), .irq(irq));

    ////////////////////////////////////////
    // Shared tasks
    task automatic end_of_test();
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data exist only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        q = rdata;
        if (m != 8'h00) chk(what, e & m, q & m);
    endtask : rd_chk
    task automatic wait_en(input logic v);
        int i;
        for (i = 0; i < 20 && tx_enable !== v; i++) @(negedge clk);
        chk("tx_enable", {7'h00, v}, {7'h00, tx_enable});
        if (tx_enable !== v) end_of_test();
    endtask : wait_en
    task automatic pin(input int i, input logic v);
        @(posedge clk);
        want_n[i] <= v;
        wait_n(7);
    endtask : pin

    ////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk("idle flags", 8'h01, {6'h00, msi_req, tx_enable});
        rd_chk(ADDR_LINE_STATUS, 8'hFF, 8'h00, "status");
        rd_chk(3'h6, 8'hFF, 8'h00, "unmapped");
        wr_reg(ADDR_LINE_STATUS, 8'hFF);
        rd_chk(ADDR_LINE_STATUS, 8'hFF, 8'h00, "status ro");
    endtask : t_reset
    task automatic t_scratch();
        logic [7:0] v[4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
        foreach (v[k]) begin
            wr_reg(ADDR_SCRATCH, v[k]);
            rd_chk(ADDR_SCRATCH, 8'hFF, v[k], "scratch");
        end
    endtask : t_scratch
    // Assert then release each line; ring only counts its release
    task automatic t_lines();
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            pin(i, 1'b0);
            chk("msi", {7'h00, i != 2}, {7'h00, msi_req});
            rd_chk(ADDR_LINE_STATUS, 8'hFF, (8'h10 << i) | ((i != 2) << i), "assert");
            rd_chk(ADDR_LINE_STATUS, 8'h0F, 8'h00, "cleared");
            pin(i, 1'b1);
            rd_chk(ADDR_LINE_STATUS, 8'hFF, 8'h01 << i, "release");
        end
        slow <= 1'b0;
        // Read strobe sampled on the edge that records the change: the change must outlive the clear
        @(posedge clk);
        want_n[LINE_CTS] <= 1'b0;
        wait_n(2);
        rd_chk(ADDR_LINE_STATUS, 8'hFF, 8'h00, "read on change");
        rd_chk(ADDR_LINE_STATUS, 8'hFF, 8'h11, "cts change kept");
    endtask : t_lines
    task automatic t_loop();
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADDR_LINE_CONTROL, 8'h10 | (8'h01 << k));
            wait_n(3);
            chk("pins forced", 8'h0F, {4'h0, ctl_n});
            rd_chk(ADDR_LINE_STATUS, 8'hF0, 8'h01 << lb[k], "loop level");
        end
        wr_reg(ADDR_LINE_CONTROL, 8'h0F);
        wait_n(1);
        chk("pins on", 8'h00, {4'h0, ctl_n});
        rd_chk(ADDR_LINE_CONTROL, 8'hFF, 8'h0F, "control");
        wr_reg(ADDR_LINE_CONTROL, 8'h00);
        wait_n(5);
        rd_chk(ADDR_LINE_STATUS, 8'hF0, 8'h10, "back to pins");
    endtask : t_loop
    task automatic t_flow();
        wr_reg(ADDR_FEATURE, 8'h80);
        wait_en(1'b1);
        tx_busy <= 1'b1;
        pin(0, 1'b1);
        chk("busy hold", 8'h01, {7'h00, tx_enable});
        tx_busy <= 1'b0;
        wait_en(1'b0);
        pin(0, 1'b0);
        wait_en(1'b1);
        pin(0, 1'b1);
        wait_en(1'b0);
        rd_chk(ADDR_FEATURE, 8'hFF, 8'h80, "feature");
        wr_reg(ADDR_FEATURE, 8'h00);
        wait_en(1'b1);
        rd_chk(ADDR_LINE_STATUS, 8'h00, 8'h00, "");
    endtask : t_flow
    task automatic t_irq();
        wr_reg(ADDR_IRQ_MASK, 8'h0F);
        wr_reg(ADDR_IRQ_STATUS, 8'h0F);
        wait_n(2);
        chk("irq clear", 8'h00, {7'h00, irq});
        pin(3, 1'b0);
        chk("irq on", 8'h03, {6'h00, msi_req, irq});
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        wait_n(1);
        chk("irq masked", 8'h02, {6'h00, msi_req, irq});
        wr_reg(ADDR_IRQ_MASK, 8'h08);
        rd_chk(ADDR_IRQ_MASK, 8'h0F, 8'h08, "irq mask");
        rd_chk(ADDR_IRQ_STATUS, 8'h0F, 8'h08, "irq status");
        chk("irq unmasked", 8'h01, {7'h00, irq});
        wr_reg(ADDR_IRQ_STATUS, 8'h08);
        rd_chk(ADDR_LINE_STATUS, 8'h0F, 8'h08, "dcd change");
        wait_n(1);
        chk("all clear", 8'h00, {6'h00, msi_req, irq});
    endtask : t_irq

    initial begin
        wait_n(8);
        rst <= 1'b0;
        t_reset();
        t_scratch();
        t_lines();
        t_loop();
        t_flow();
        t_irq();
        rst <= 1'b1;
        wait_n(3);
        rst <= 1'b0;
        chk("reset flags", 8'hF1, {ctl_n, 1'b0, irq, msi_req, tx_enable});
        rd_chk(ADDR_SCRATCH, 8'hFF, 8'h00, "scratch after reset");
        end_of_test();
    end
endmodule : tb_uart_modem_status_tracker

bind uart_modem_status_tracker modem_status_checker chk_i (.*);
